// *** design/eeprom_consts.vh ***
// Constants for the serial protected EEPROM command block.
// Assumes a 100 MHz system clock; serial pins arrive asynchronously.
// What this block does
// - Sample input bits on serial clock rise
// - Read loads word, emits zero dummy first
// - Output bit changes on each rising edge
// - Continued clocking reads next word, no dummy
// - Power-up state is write disabled
// - Write enable holds until write disable
// - Word write: 16 bits, chip select fall programs
// - Status output: low busy, high ready
// - Chip select low resets command sequencing
// - Write all only with protect cleared
// - Write disable blocks programming, reads unaffected
// - Protect select low routes to array
// - Protect read: dummy zero then address
// - Protect enable needs write enabled, pins high
// - Protect ops need protect enable just before
// - Protect clear unprotects all words
// - Cleared differs from all-ones protect write
// - Protect write blocks addresses at or above
// - Protect lock is one-time, freezes register
// - Start bit, two-bit opcode, six address bits
// - Special group decode by address prefix
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

`define OP_READ      2'h2
`define OP_WRITE     2'h1
`define OP_SPECIAL   2'h0
`define OP_PCLEAR    2'h3
`define PFX_ENABLE   2'h3
`define PFX_WALL     2'h1
`define PFX_DISABLE  2'h0
`define ADDR_ALL1    6'h3f
`define CMD_BITS     9
`define WORD_BITS    16
`define PROT_RESET   4'hf
// Self-timed program time, in microseconds
`define T_PROG_US    15000
`define CLK_MHZ      100
`define T_PROG_CYC   (`T_PROG_US * `CLK_MHZ)
// Minimum chip select low time, in nanoseconds
`define T_CS_NS      1000
`define CLK_NS       10
`define T_CS_CYC     ((`T_CS_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** design/eeprom_cmd.v ***
// Serial command logic of a 16 x 16 protected EEPROM.
// Assumes chip_select, serial_clock_in, serial_in and the two pins are asynchronous
// and pass through two flip-flops here; all logic runs on clk.
`include "eeprom_consts.vh"

module eeprom_cmd #(
  parameter PROG_CYCLES = `T_PROG_CYC,
  parameter CSLOW_CYCLES = `T_CS_CYC
) (
  // System
  input  wire        clk,
  input  wire        rst,
  // Serial pins
  input  wire        chip_select,
  input  wire        serial_clock_in,
  input  wire        serial_in,
  input  wire        program_enable_pin,
  input  wire        protect_select,
  output reg         serial_out,
  output reg         serial_out_oe,
  // Status
  output wire        write_enabled,
  output wire        prog_busy,
  output wire        protect_locked,
  output wire [3:0]  protect_addr
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg [1:0] cs_s_q;
  reg [1:0] sk_s_q;
  reg [1:0] di_s_q;
  reg [1:0] pe_s_q;
  reg [1:0] pre_s_q;
  reg       sk_d1_q;
  always @(posedge clk) begin
    cs_s_q  <= {cs_s_q[0], chip_select};
    sk_s_q  <= {sk_s_q[0], serial_clock_in};
    di_s_q  <= {di_s_q[0], serial_in};
    pe_s_q  <= {pe_s_q[0], program_enable_pin};
    pre_s_q <= {pre_s_q[0], protect_select};
    sk_d1_q <= sk_s_q[1];
  end
  wire cs  = cs_s_q[1];
  wire di  = di_s_q[1];
  wire pe  = pe_s_q[1];
  wire pre = pre_s_q[1];
  wire sk_rise = sk_s_q[1] & ~sk_d1_q & cs;

  // ************************************************************
  // State
  // ************************************************************
  localparam ST_IDLE  = 4'h1;
  localparam ST_CMD   = 4'h2;
  localparam ST_DATA  = 4'h4;
  localparam ST_OUT   = 4'h8;

  reg [15:0] mem_q [0:15];
  reg [3:0]  state_q;
  reg [3:0]  cnt_q;
  reg [8:0]  cmd_q;
  reg [15:0] sh_q;
  reg        pe_ok_q;
  reg        pre_q;
  reg        wen_q;
  reg        protect_enable_cmd_q;
  reg        cleared_q;
  reg        lock_q;
  reg [3:0]  prot_q;
  reg [3:0]  raddr_q;
  reg        out_prot_q;
  reg        dummy_q;
  reg [4:0]  ocnt_q;
  reg [23:0] prog_q;
  reg        prog_all_q;
  reg        prog_pend_q;
  reg [3:0]  paddr_q;
  reg [15:0] pdata_q;
  reg [7:0]  cslow_q;
  reg        cs_q;
  reg        long_low_seen_q;
  reg        status_q;
  integer    i;

  wire [1:0] op   = cmd_q[7:6];
  wire [5:0] addr = cmd_q[5:0];
  wire [8:0] cmd_n = {cmd_q[7:0], di};
  wire [1:0] op_n = cmd_n[7:6];
  wire       busy = (prog_q != 24'h0);
  wire       cs_fall = cs_q & ~cs;
  wire       long_low = (cslow_q >= CSLOW_CYCLES[7:0]);
  // Protect of the last word is distinguished by cleared flag
  wire       word_prot = ~cleared_q & (addr[3:0] >= prot_q);

  assign write_enabled  = wen_q;
  assign prog_busy      = busy;
  assign protect_locked = lock_q;
  assign protect_addr   = prot_q;

  // ************************************************************
  // Self-timed programming
  // ************************************************************
  // Memory changes only when the program time has run out
  always @(posedge clk) begin
    cs_q <= cs;
    if (rst) begin
      prog_q  <= 24'h0;
      cslow_q <= 8'h0;
    end else begin
      // Programming starts on chip select falling
      if (cs_fall && prog_pend_q && state_q == ST_DATA && cnt_q == 4'h0) begin
        prog_q <= PROG_CYCLES[23:0];
      end else if (busy) begin
        prog_q <= prog_q - 24'h1;
      end
      if (prog_q == 24'h1) begin
        if (prog_all_q) begin
          for (i = 0; i < 16; i = i + 1) begin
            mem_q[i] <= pdata_q;
          end
        end else begin
          mem_q[paddr_q] <= pdata_q;
        end
      end
      // Saturates, so a long idle never wraps back to short
      if (cs) begin
        cslow_q <= 8'h0;
      end else if (!long_low) begin
        cslow_q <= cslow_q + 8'h1;
      end
    end
  end

  // ************************************************************
  // Command engine
  // ************************************************************
  // Serial clocks are ignored while busy; the host polls status instead
  always @(posedge clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      cmd_q       <= 9'h0;
      sh_q        <= 16'h0;
      pe_ok_q     <= 1'b0;
      pre_q       <= 1'b0;
      wen_q       <= 1'b0;
      protect_enable_cmd_q      <= 1'b0;
      cleared_q   <= 1'b1;
      lock_q      <= 1'b0;
      prot_q      <= `PROT_RESET;
      raddr_q     <= 4'h0;
      out_prot_q  <= 1'b0;
      dummy_q     <= 1'b0;
      ocnt_q      <= 5'h0;
      prog_all_q  <= 1'b0;
      prog_pend_q <= 1'b0;
      paddr_q     <= 4'h0;
      pdata_q     <= 16'h0;
    end else begin
      if (cs_fall) prog_pend_q <= 1'b0;
      if (!cs) begin
        state_q <= ST_IDLE;
        cnt_q <= 4'h0;
      end else if (sk_rise && !busy) begin
        case (state_q)
          ST_IDLE: begin
            if (di && long_low_seen_q) begin
              state_q <= ST_CMD;
              cnt_q   <= 4'h0;
              cmd_q   <= 9'h1;
              pe_ok_q <= pe;
              pre_q   <= pre;
            end
          end
          ST_CMD: begin
            cmd_q <= cmd_n;
            pe_ok_q <= pe_ok_q & pe;
            pre_q <= pre_q & pre;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              protect_enable_cmd_q <= 1'b0;
              state_q <= ST_IDLE;
              if (op_n == `OP_READ) begin
                state_q <= ST_OUT;
                dummy_q <= 1'b1;
                ocnt_q  <= 5'h0;
                out_prot_q <= pre_q & pre;
                raddr_q <= cmd_n[3:0] + 4'h1;
                sh_q <= (pre_q & pre) ? {12'h0, prot_q} : mem_q[cmd_n[3:0]];
              end else if (op_n == `OP_WRITE && !(pre_q & pre)) begin
                state_q <= ST_DATA;
                cnt_q   <= 4'h0;
              end else if (op_n == `OP_WRITE && pre_q & pre && pe_ok_q & pe && protect_enable_cmd_q && !lock_q) begin
                prot_q    <= cmd_n[3:0];
                cleared_q <= 1'b0;
              end else if (op_n == `OP_PCLEAR && cmd_n[5:0] == `ADDR_ALL1
                           && pre_q & pre && pe_ok_q & pe && protect_enable_cmd_q && !lock_q) begin
                prot_q    <= `PROT_RESET;
                cleared_q <= 1'b1;
              end else if (op_n == `OP_SPECIAL) begin
                if (cmd_n[5:4] == `PFX_ENABLE) begin
                  if (!(pre_q & pre)) begin
                    if (pe_ok_q & pe) wen_q <= 1'b1;
                  end else if (wen_q && pe_ok_q & pe) begin
                    protect_enable_cmd_q <= 1'b1;
                  end
                end else if (cmd_n[5:4] == `PFX_DISABLE) begin
                  if (!(pre_q & pre)) wen_q <= 1'b0;
                  else if (pe_ok_q & pe && protect_enable_cmd_q && !lock_q) lock_q <= 1'b1;
                end else if (cmd_n[5:4] == `PFX_WALL && !(pre_q & pre)) begin
                  state_q <= ST_DATA;
                  cnt_q   <= 4'h0;
                end
              end
            end
          end
          ST_DATA: begin
            sh_q <= {sh_q[14:0], di};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hf) begin
              pdata_q <= {sh_q[14:0], di};
              prog_all_q <= (op == `OP_SPECIAL);
              paddr_q <= addr[3:0];
              // Refused commands never arm programming
              prog_pend_q <= wen_q & pe_ok_q &
                             ((op == `OP_SPECIAL) ? cleared_q : ~word_prot);
            end else begin
              prog_pend_q <= 1'b0;
            end
          end
          ST_OUT: begin
            if (dummy_q) begin
              dummy_q <= 1'b0;
            end else begin
              ocnt_q <= ocnt_q + 5'h1;
              sh_q <= {sh_q[14:0], 1'b0};
              if (ocnt_q == 5'hf) begin
                ocnt_q <= 5'h0;
                if (!out_prot_q) begin
                  sh_q <= mem_q[raddr_q];
                  raddr_q <= raddr_q + 4'h1;
                end
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // A command needs a fresh long low interval first
  always @(posedge clk) begin
    if (rst) long_low_seen_q <= 1'b1;
    else if (!cs && long_low) long_low_seen_q <= 1'b1;
    else if (state_q != ST_IDLE) long_low_seen_q <= 1'b0;
  end

  // ************************************************************
  // Serial output driver
  // ************************************************************
  always @(posedge clk) begin
    if (rst || !cs) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (state_q == ST_OUT) begin
      serial_out <= dummy_q ? 1'b0 : sh_q[15];
      serial_out_oe <= 1'b1;
    end else if (state_q == ST_IDLE && status_q) begin
      // Status only follows a started program cycle, never a refused one
      serial_out    <= ~busy;
      serial_out_oe <= 1'b1;
    end else begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
  end

  // ************************************************************
  // Ready/busy status window
  // ************************************************************
  // Status shown after a program cycle until the next start bit
  always @(posedge clk) begin
    if (rst) status_q <= 1'b0;
    else if (cs_fall && prog_pend_q) status_q <= 1'b1;
    else if (state_q != ST_IDLE) status_q <= 1'b0;
  end

endmodule // eeprom_cmd

// *** verification/eeprom_cmd_sva.sv ***
// Port assertions for the serial EEPROM command block.
// Bound to eeprom_cmd; assumes one clock and a host that keeps the serial timing.
module eeprom_cmd_sva #(
  parameter int PROG_CYCLES  = 50,
  parameter int CSLOW_CYCLES = 4
) (
  // System
  input wire logic       clk,
  input wire logic       rst,
  // Serial pins
  input wire logic       chip_select,
  input wire logic       serial_clock_in,
  input wire logic       serial_in,
  input wire logic       program_enable_pin,
  input wire logic       protect_select,
  input wire logic       serial_out,
  input wire logic       serial_out_oe,
  // Status
  input wire logic       write_enabled,
  input wire logic       prog_busy,
  input wire logic       protect_locked,
  input wire logic [3:0] protect_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  cs_hi;
  logic [3:0]  sk_age;
  logic [31:0] busy_n;
  logic        sk_q;
  // ****
  // Helper counters
  // ****
  // cs_hi and sk_age saturate, so a long read never looks like a fresh status window
  always @(posedge clk) begin
    sk_q   <= serial_clock_in;
    cs_hi  <= !chip_select ? 8'h00 : cs_hi + {7'h00, cs_hi != 8'hff};
    sk_age <= (serial_clock_in && !sk_q) ? 4'h0 : sk_age + {3'h0, sk_age != 4'hf};
    busy_n <= prog_busy ? busy_n + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_off_deselect: assert property (!chip_select [*6] |-> !serial_out_oe)
    else $error("output enabled while deselected");
  a_busy_needs_we: assert property (prog_busy |-> write_enabled)
    else $error("programming while write disabled");
  a_busy_cs_low: assert property ($rose(prog_busy) |-> !chip_select && !$past(chip_select))
    else $error("programming began with chip select high");
  a_busy_length: assert property ($fell(prog_busy) |-> busy_n + 1 >= PROG_CYCLES && busy_n <= PROG_CYCLES + 1)
    else $error("program time wrong");
  a_addr_gated: assert property ($changed(protect_addr) |-> write_enabled && !$past(protect_locked))
    else $error("protect address changed without enable");
  a_lock_frozen: assert property ($past(protect_locked) |-> protect_locked && $stable(protect_addr))
    else $error("locked protect register changed");
  a_dummy_bit_first: assert property ($rose(serial_out_oe) && cs_hi > 8'h50 |-> !serial_out)
    else $error("read did not start with a zero bit");
  a_out_on_rise: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) && cs_hi > 8'h50
    |-> sk_age <= 4'h6)
    else $error("output changed without a serial clock rise");
  c_program: cover property ($rose(prog_busy));
  c_lock: cover property ($rose(protect_locked));
  c_read: cover property ($rose(serial_out_oe) && cs_hi > 8'h50);
endmodule // eeprom_cmd_sva

bind eeprom_cmd eeprom_cmd_sva #(.PROG_CYCLES(PROG_CYCLES), .CSLOW_CYCLES(CSLOW_CYCLES)) chk (.clk, .rst,
  .chip_select, .serial_clock_in, .serial_in, .program_enable_pin, .protect_select, .serial_out,
  .serial_out_oe, .write_enabled, .prog_busy, .protect_locked, .protect_addr);

// *** verification/eeprom_host.sv ***
// Host model driving the serial pins of the EEPROM.
// Assumes the bench calls one task at a time; pins move 1 ns after clk rises.
module eeprom_host (
  // System
  input  wire logic clk,
  // Serial pins
  output logic      chip_select,
  output logic      serial_clock_in,
  output logic      serial_in,
  output logic      program_enable_pin,
  output logic      protect_select,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chip_select        = 1'b0;
    serial_clock_in    = 1'b0;
    serial_in          = 1'b0;
    program_enable_pin = 1'b0;
    protect_select     = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Serial clock period of 16 clk, well above the sampling latency
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = v[i];
      tick(8);
      serial_clock_in = 1'b1;
      tick(8);
      serial_clock_in = 1'b0;
    end
  endtask
  task automatic start(input logic [1:0] pp, input logic [8:0] c);
    tick(10);
    {protect_select, program_enable_pin} = pp;
    chip_select = 1'b1;
    tick(4);
    shift({7'h00, c}, 9);
  endtask
  // Pins become don't-care after loading, so flip them
  task automatic finish;
    chip_select = 1'b0;
    serial_in   = ~serial_in;
    {protect_select, program_enable_pin} = ~{protect_select, program_enable_pin};
  endtask
  task automatic read(input int n, output logic d0, output logic [31:0] w);
    tick(8);
    d0 = serial_out | ~serial_out_oe;
    w  = 32'h0;
    for (int i = 0; i < n; i++) begin
      serial_clock_in = 1'b1;
      tick(8);
      serial_clock_in = 1'b0;
      tick(8);
      w = {w[30:0], serial_out & serial_out_oe};
    end
    finish();
  endtask
  task automatic status(output logic busy0, output logic rdy);
    tick(10);
    chip_select = 1'b1;
    tick(6);
    busy0 = serial_out_oe & ~serial_out;
    rdy   = 1'b0;
    for (int i = 0; i < 200 && !rdy; i++) begin
      tick(1);
      rdy = serial_out_oe & serial_out;
    end
    chip_select = 1'b0;
  endtask
endmodule // eeprom_host

// *** verification/serial_eeprom_protect_cmd_bench.sv ***
// Self-checking bench for the serial EEPROM command block.
// Assumes eeprom_host as the far side and the bound port checker.
module serial_eeprom_protect_cmd_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  wire         chip_select, serial_clock_in, serial_in, program_enable_pin, protect_select;
  wire         serial_out, serial_out_oe, write_enabled, prog_busy, protect_locked;
  wire  [3:0]  protect_addr;
  int          err_count = 0;
  int          n_tests = 0;
  logic [15:0] mem [16];
  logic [15:0] d, pat;
  logic [3:0]  a, p;
  initial begin
    forever #5 clk = ~clk;
  end
  eeprom_cmd #(.PROG_CYCLES(50), .CSLOW_CYCLES(4)) dut (.clk, .rst, .chip_select, .serial_clock_in, .serial_in,
    .program_enable_pin, .protect_select, .serial_out, .serial_out_oe, .write_enabled, .prog_busy,
    .protect_locked, .protect_addr);
  eeprom_host host (.clk, .chip_select, .serial_clock_in, .serial_in, .program_enable_pin, .protect_select,
    .serial_out, .serial_out_oe);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Kind 1 expects a program cycle, 2 a silent refusal
  task automatic op(input logic [1:0] pp, input logic [8:0] c, input int kind);
    logic b0, rdy;
    host.start(pp, c);
    if (!pp[1] && (c[7:6] == 2'h1 || c[7:4] == 4'h1))
      host.shift(d, 16);
    host.finish();
    if (kind == 1) begin
      host.status(b0, rdy);
      check("status", {b0, rdy}, 2'h3);
    end
    host.tick(8);
    if (kind == 2)
      check("prog_busy", prog_busy, 1'b0);
    for (int i = 0; i < 300 && prog_busy !== 1'b0; i++)
      host.tick(1);
    if (prog_busy !== 1'b0) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic rd(input logic pre, input logic [3:0] at, input int n, input logic [31:0] exp);
    logic d0;
    logic [31:0] w;
    host.start({pre, 1'b0}, {5'h18, at});
    host.read(n, d0, w);
    check("dummy", d0, 1'b0);
    check("read", w, exp);
    $display("read test done");
  endtask
  initial begin
    void'($urandom(85));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    host.tick(4);
    check("power-up", {write_enabled, protect_addr}, 5'h0f);
    d = 16'($urandom);
    op(2'h1, 9'h143, 2);
    op(2'h1, 9'h130, 0);
    check("write_enabled", write_enabled, 1'b1);
    pat = 16'($urandom);
    d = pat;
    op(2'h1, 9'h110, 1);
    foreach (mem[i]) mem[i] = pat;
    a = 4'($urandom);
    d = ~pat;
    op(2'h1, {5'h14, a}, 1);
    mem[a] = d;
    op(2'h0, {5'h14, a}, 2);
    rd(1'b0, a - 4'h1, 48, {mem[a], mem[a + 4'h1]});
    op(2'h3, 9'h130, 0);
    op(2'h3, 9'h1ff, 0);
    d = 16'($urandom);
    op(2'h1, 9'h14f, 1);
    mem[15] = d;
    op(2'h3, 9'h130, 0);
    op(2'h3, 9'h14f, 0);
    op(2'h1, 9'h14f, 2);
    op(2'h1, 9'h110, 2);
    $display("all-ones protect test done");
    op(2'h3, 9'h130, 0);
    op(2'h3, 9'h1ff, 0);
    p = 4'h1 + 4'($urandom % 14);
    op(2'h3, 9'h130, 0);
    op(2'h3, {5'h14, p}, 0);
    check("protect_addr", protect_addr, p);
    op(2'h1, {5'h14, p}, 2);
    op(2'h1, {5'h14, p - 4'h1}, 1);
    mem[p - 4'h1] = d;
    rd(1'b1, 4'h0, 16, {28'h0, p});
    op(2'h3, 9'h1ff, 0);
    check("protect_addr", protect_addr, p);
    op(2'h3, 9'h130, 0);
    op(2'h3, 9'h100, 0);
    op(2'h3, 9'h130, 0);
    op(2'h3, 9'h1ff, 0);
    check("lock", {protect_locked, protect_addr}, {1'b1, p});
    op(2'h1, 9'h100, 0);
    check("write_enabled", write_enabled, 1'b0);
    op(2'h1, 9'h140, 2);
    rd(1'b0, p - 4'h1, 32, {mem[p - 4'h1], mem[p]});
    stop_test();
  end
endmodule // serial_eeprom_protect_cmd_bench
